// ===== bench/bgp_host_model.sv
// Register host driving the strobe port from the falling edge
`timescale 1ns/1ps
`default_nettype none
module bgp_host_model
(
	input wire logic               clk,
	input wire bgp_pkg::bgp_byte_t regRdData,
	input wire logic               regRdValid,
	output var bgp_pkg::bgp_byte_t regAddr,
	output var bgp_pkg::bgp_byte_t regWrData,
	output var logic               regWrEn,
	output var logic               regRdEn
);
	import bgp_pkg::*;
	initial {regAddr, regWrData, regWrEn, regRdEn} = '0;
	// Caller stands on a falling edge; strobe lasts one cycle
	task wr(input bgp_byte_t a, input bgp_byte_t d);
		{regAddr, regWrData, regWrEn} = {a, d, 1'b1};
		@(negedge clk);
		regWrEn = 1'b0;
	endtask
	task rd(input bgp_byte_t a, output bgp_byte_t d, output logic v);
		{regAddr, regRdEn} = {a, 1'b1};
		@(negedge clk);
		{v, d} = {regRdValid, regRdData};
		regRdEn = 1'b0;
	endtask
endmodule // bgp_host_model
`default_nettype wire

// ===== bench/bgp_top_props.sv
// Port assertions for the button group and polarity bank
`timescale 1ns/1ps
`default_nettype none
module bgp_top_props
(
	input wire logic                clk,
	input wire logic                rst,
	input wire bgp_pkg::bgp_byte_t  regAddr,
	input wire bgp_pkg::bgp_byte_t  regWrData,
	input wire logic                regWrEn,
	input wire logic                regRdEn,
	input wire bgp_pkg::bgp_byte_t  regRdData,
	input wire logic                regRdValid,
	input wire logic                algoUpdate,
	input wire bgp_pkg::bgp_value_t coil_frequency_ch0,
	input wire bgp_pkg::bgp_mask_t  buttonPressed,
	input wire bgp_pkg::bgp_value_t processed_value_ch0,
	input wire logic                button_pin_ch3,
	input wire bgp_pkg::bgp_mask_t  commonGroupMask,
	input wire bgp_pkg::bgp_mask_t  deformGroupMask
);
	import bgp_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_read_valid: assert property (regRdEn |=> regRdValid)
		else $error("read strobe without valid pulse");
	chk_read_back: assert property ((regWrEn && regAddr == 8'h1A) ##1
		(regRdEn && regAddr == 8'h1A && !regWrEn) |=> regRdData == $past(regWrData, 2))
		else $error("group register read back wrong");
	chk_unmapped_zero: assert property (regRdEn && regAddr != 8'h1A && regAddr != 8'h1C
		|=> regRdData == 8'h00) else $error("unmapped read not zero");
	chk_mask_load: assert property ((regWrEn && regAddr == 8'h1A) ##1
		(algoUpdate && !regWrEn) |=> {commonGroupMask, deformGroupMask} == $past(regWrData, 2))
		else $error("group masks not loaded");
	chk_mask_hold: assert property (!algoUpdate |=> $stable(commonGroupMask)
		&& $stable(deformGroupMask)) else $error("group masks moved without update");
	chk_pin_level: assert property ((regWrEn && regAddr == 8'h1C) ##1 !regWrEn
		|=> button_pin_ch3 == ($past(regWrData[7], 2) ~^ $past(buttonPressed[3])))
		else $error("pin level wrong");
	chk_value_sign: assert property ((regWrEn && regAddr == 8'h1C) ##1
		(algoUpdate && !regWrEn) |=> processed_value_ch0 == ($past(regWrData[0], 2)
		? $past(coil_frequency_ch0) : -$past(coil_frequency_ch0)))
		else $error("value sign wrong");
endmodule // bgp_top_props
bind bgp_top bgp_top_props props (.clk, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn,
	.regRdData, .regRdValid, .algoUpdate, .coil_frequency_ch0, .buttonPressed,
	.processed_value_ch0, .button_pin_ch3, .commonGroupMask, .deformGroupMask);
`default_nettype wire

// ===== bench/tb_button_group_polarity_config.sv
// Testbench for the button group and polarity bank
`timescale 1ns/1ps
`default_nettype none
module tb_button_group_polarity_config;
	import bgp_pkg::*;
	logic       clk = 0, rst = 1, algoUpdate = 0, regWrEn, regRdEn, regRdValid, p0, p1, p2, p3;
	bgp_byte_t  regAddr, regWrData, regRdData;
	bgp_value_t raw = 16'sh0064, pv0, pv1, pv2, pv3;
	bgp_mask_t  prs = 4'h3, cgm, dgm;
	int         nMismatch = 0, comparisons = 0;
	always #20 clk = ~clk;
	bgp_host_model host (.clk, .regRdData, .regRdValid, .regAddr, .regWrData, .regWrEn, .regRdEn);
	bgp_top dut (.clk, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .regRdValid,
		.algoUpdate, .coil_frequency_ch0(raw), .coil_frequency_ch1(raw),
		.coil_frequency_ch2(raw), .coil_frequency_ch3(raw), .buttonPressed(prs),
		.processed_value_ch0(pv0), .processed_value_ch1(pv1), .processed_value_ch2(pv2),
		.processed_value_ch3(pv3), .button_pin_ch0(p0), .button_pin_ch1(p1),
		.button_pin_ch2(p2), .button_pin_ch3(p3), .commonGroupMask(cgm), .deformGroupMask(dgm));
	task cmp(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task rdchk(input bgp_byte_t a, input bgp_byte_t e);
		bgp_byte_t d;
		logic      v;
		host.rd(a, d, v);
		cmp({v, d}, {1'b1, e});
	endtask
	task upd;
		algoUpdate = 1'b1;
		@(negedge clk);
		algoUpdate = 1'b0;
	endtask
	task t_reset;
		rdchk(8'h1A, 8'h00);
		@(negedge clk);
		rdchk(8'h1C, 8'h0F);
		cmp({p3, p2, p1, p0}, bgp_mask_t'(~prs));
	endtask
	task t_groups;
		host.wr(8'h1A, 8'hA5);
		cmp({cgm, dgm}, 8'h00);
		upd;
		cmp({cgm, dgm}, 8'hA5);
		host.wr(8'h1A, 8'h3C);
		rdchk(8'h1A, 8'h3C);
		cmp({cgm, dgm}, 8'hA5);
		host.wr(8'h1B, 8'hFF);
		rdchk(8'h1B, 8'h00);
	endtask
	task t_pol;
		host.wr(8'h1C, 8'h5A);
		@(negedge clk);
		cmp({p3, p2, p1, p0}, bgp_mask_t'(~(4'h5 ^ prs)));
		upd;
		cmp({pv3, pv2, pv1, pv0}, {raw, -raw, raw, -raw});
		host.wr(8'h1C, 8'hF0);
		upd;
		cmp({p3, p2, p1, p0}, prs);
		cmp({pv3, pv2, pv1, pv0}, {-raw, -raw, -raw, -raw});
		prs = 4'hC;
		@(negedge clk);
		cmp({p3, p2, p1, p0}, 4'hC);
		rdchk(8'h1C, 8'hF0);
		raw = 16'sh8000;
		upd;
		cmp({pv3, pv2, pv1, pv0}, {4{16'sh7FFF}});
		raw = 16'sh0064;
	endtask
	task t_rerst;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		cmp({cgm, dgm}, 8'h00);
		rdchk(8'h1A, 8'h00);
		rdchk(8'h1C, 8'h0F);
		cmp({p3, p2, p1, p0}, bgp_mask_t'(~prs));
	endtask
	task conclude;
		$display("mismatches=%0d comparisons=%0d", nMismatch, comparisons);
		if (nMismatch == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		nMismatch++;
		conclude;
	end
	initial
	begin
		repeat (5) @(negedge clk);
		rst = 0;
		@(negedge clk);
		t_reset;
		t_groups;
		t_pol;
		t_rerst;
		conclude;
	end
endmodule // tb_button_group_polarity_config
`default_nettype wire

// ===== logic/bgp_channel.sv
// One channel: sign of the processed value and active level of the button pin
`timescale 1ns/1ps
`default_nettype none
`include "bgp_consts.svh"

module bgp_channel
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        algoUpdate,
	input  wire logic        valueSignSel,
	input  wire logic        pinLevelSel,
	input  wire logic        buttonPressed,
	input  wire bgp_pkg::bgp_value_t rawValue,
	output var  bgp_pkg::bgp_value_t processedValue,
	output logic             buttonPin
);
	import bgp_pkg::*;

	bgp_value_t processedValue_q;
	bgp_value_t processedValue_d;
	logic       buttonPin_q;
	logic       buttonPin_d;
	logic       rawIsMin;
	bgp_value_t negated;

	// Negating the most negative value would wrap, so it saturates instead
	assign rawIsMin = (rawValue == `BGP_VALUE_MIN);
	assign negated  = rawIsMin ? `BGP_VALUE_MAX : -rawValue;

	// Raw value rises with coil frequency; a clear sign bit turns it round
	assign processedValue_d = algoUpdate
		? (valueSignSel ? rawValue : negated)
		: processedValue_q;

	// Active low unless the level bit is set; follows the bit without waiting for an update
	assign buttonPin_d = pinLevelSel ? buttonPressed : ~buttonPressed;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			processedValue_q <= `BGP_VALUE_ZERO;
			buttonPin_q      <= 1'b1;
		end
		else
		begin
			processedValue_q <= processedValue_d;
			buttonPin_q      <= buttonPin_d;
		end
	end

	assign processedValue = processedValue_q;
	assign buttonPin      = buttonPin_q;
endmodule // bgp_channel

`default_nettype wire

// ===== logic/bgp_consts.svh
// Register map, field positions and reset values of the button group and polarity bank
`ifndef BGP_CONSTS_SVH
`define BGP_CONSTS_SVH

`define BGP_ADDR_GROUPS     8'h1A
`define BGP_ADDR_POLARITY   8'h1C
`define BGP_RST_GROUPS      8'h00
`define BGP_RST_POLARITY    8'h0F
`define BGP_READ_UNMAPPED   8'h00

`define BGP_COMMON_MSB      7
`define BGP_COMMON_LSB      4
`define BGP_DEFORM_MSB      3
`define BGP_DEFORM_LSB      0
`define BGP_LEVEL_MSB       7
`define BGP_LEVEL_LSB       4
`define BGP_SIGN_MSB        3
`define BGP_SIGN_LSB        0

`define BGP_CHANNELS        4
`define BGP_VALUE_MAX       16'sh7FFF
`define BGP_VALUE_MIN       16'sh8000
`define BGP_VALUE_ZERO      16'sh0000
`define BGP_MASK_ZERO       4'h0

`endif

// ===== logic/bgp_pkg.sv
// Types shared by the button group and polarity bank
`default_nettype none

package bgp_pkg;
	typedef logic [7:0]         bgp_byte_t;
	typedef logic [3:0]         bgp_mask_t;
	typedef logic signed [15:0] bgp_value_t;
endpackage

`default_nettype wire

// ===== logic/bgp_top.sv
// Group membership and polarity registers of a four-channel button sensor
`timescale 1ns/1ps
`default_nettype none
`include "bgp_consts.svh"

// What this block does
// - Group register bits 7..4 put channels 3..0 into the common-mode group.
// - Group register bits 3..0 put channels 3..0 into the deformation group.
// - Group register at 0x1A is read-write and resets to zero.
// - Polarity bits 7..4 make button pins 3..0 active high; clear means active low.
// - Polarity bits 3..0 set: value rises with coil frequency; clear: it falls.
// - Polarity register at 0x1C is read-write and resets to 0x0F.
module bgp_top
(
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire bgp_pkg::bgp_byte_t regAddr,
	input  wire bgp_pkg::bgp_byte_t regWrData,
	input  wire logic               regWrEn,
	input  wire logic               regRdEn,
	output var  bgp_pkg::bgp_byte_t regRdData,
	output logic                    regRdValid,
	input  wire logic               algoUpdate,
	input  wire bgp_pkg::bgp_value_t coil_frequency_ch0,
	input  wire bgp_pkg::bgp_value_t coil_frequency_ch1,
	input  wire bgp_pkg::bgp_value_t coil_frequency_ch2,
	input  wire bgp_pkg::bgp_value_t coil_frequency_ch3,
	input  wire bgp_pkg::bgp_mask_t buttonPressed,
	output var  bgp_pkg::bgp_value_t processed_value_ch0,
	output var  bgp_pkg::bgp_value_t processed_value_ch1,
	output var  bgp_pkg::bgp_value_t processed_value_ch2,
	output var  bgp_pkg::bgp_value_t processed_value_ch3,
	output logic                    button_pin_ch0,
	output logic                    button_pin_ch1,
	output logic                    button_pin_ch2,
	output logic                    button_pin_ch3,
	output var  bgp_pkg::bgp_mask_t commonGroupMask,
	output var  bgp_pkg::bgp_mask_t deformGroupMask
);
	import bgp_pkg::*;

	bgp_byte_t  groups_q;
	bgp_byte_t  groups_d;
	bgp_byte_t  polarity_q;
	bgp_byte_t  polarity_d;
	bgp_byte_t  rdData_q;
	bgp_byte_t  rdData_d;
	logic       rdValid_q;
	bgp_mask_t  commonMask_q;
	bgp_mask_t  commonMask_d;
	bgp_mask_t  deformMask_q;
	bgp_mask_t  deformMask_d;
	bgp_mask_t  signSel_q;
	bgp_mask_t  signSel_d;

	logic       hitGroups;
	logic       hitPolarity;
	logic       wrGroups;
	logic       wrPolarity;
	bgp_mask_t  common_group_sel;
	bgp_mask_t  deform_group_sel;
	bgp_mask_t  pin_level_sel;
	bgp_mask_t  value_sign_sel;
	logic       common_group_ch0;
	logic       common_group_ch1;
	logic       common_group_ch2;
	logic       common_group_ch3;
	logic       deform_group_ch0;
	logic       deform_group_ch1;
	logic       deform_group_ch2;
	logic       deform_group_ch3;
	logic       pin_level_sel_ch0;
	logic       pin_level_sel_ch1;
	logic       pin_level_sel_ch2;
	logic       pin_level_sel_ch3;
	logic       value_sign_sel_ch0;
	logic       value_sign_sel_ch1;
	logic       value_sign_sel_ch2;
	logic       value_sign_sel_ch3;

	// Address decode
	assign hitGroups   = (regAddr == `BGP_ADDR_GROUPS);
	assign hitPolarity = (regAddr == `BGP_ADDR_POLARITY);
	assign wrGroups    = regWrEn & hitGroups;
	assign wrPolarity  = regWrEn & hitPolarity;

	assign groups_d   = wrGroups ? regWrData : groups_q;
	assign polarity_d = wrPolarity ? regWrData : polarity_q;

	// Unmapped addresses read as zero and ignore writes
	assign rdData_d = !regRdEn ? rdData_q
		: hitGroups   ? groups_q
		: hitPolarity ? polarity_q
		: `BGP_READ_UNMAPPED;

	// Field split
	assign common_group_sel = groups_q[`BGP_COMMON_MSB:`BGP_COMMON_LSB];
	assign deform_group_sel = groups_q[`BGP_DEFORM_MSB:`BGP_DEFORM_LSB];
	assign pin_level_sel    = polarity_q[`BGP_LEVEL_MSB:`BGP_LEVEL_LSB];
	assign value_sign_sel   = polarity_q[`BGP_SIGN_MSB:`BGP_SIGN_LSB];

	// Per-channel view of each field
	assign common_group_ch0   = common_group_sel[0];
	assign common_group_ch1   = common_group_sel[1];
	assign common_group_ch2   = common_group_sel[2];
	assign common_group_ch3   = common_group_sel[3];
	assign deform_group_ch0   = deform_group_sel[0];
	assign deform_group_ch1   = deform_group_sel[1];
	assign deform_group_ch2   = deform_group_sel[2];
	assign deform_group_ch3   = deform_group_sel[3];
	assign pin_level_sel_ch0  = pin_level_sel[0];
	assign pin_level_sel_ch1  = pin_level_sel[1];
	assign pin_level_sel_ch2  = pin_level_sel[2];
	assign pin_level_sel_ch3  = pin_level_sel[3];
	assign value_sign_sel_ch0 = value_sign_sel[0];
	assign value_sign_sel_ch1 = value_sign_sel[1];
	assign value_sign_sel_ch2 = value_sign_sel[2];
	assign value_sign_sel_ch3 = value_sign_sel[3];

	// Algorithm settings are taken only at an update so one pass never mixes old and new
	assign commonMask_d = algoUpdate
		? {common_group_ch3, common_group_ch2, common_group_ch1, common_group_ch0}
		: commonMask_q;
	assign deformMask_d = algoUpdate
		? {deform_group_ch3, deform_group_ch2, deform_group_ch1, deform_group_ch0}
		: deformMask_q;
	assign signSel_d    = algoUpdate
		? {value_sign_sel_ch3, value_sign_sel_ch2, value_sign_sel_ch1, value_sign_sel_ch0}
		: signSel_q;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			groups_q   <= `BGP_RST_GROUPS;
			polarity_q <= `BGP_RST_POLARITY;
		end
		else
		begin
			groups_q   <= groups_d;
			polarity_q <= polarity_d;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdData_q  <= `BGP_READ_UNMAPPED;
			rdValid_q <= 1'b0;
		end
		else
		begin
			rdData_q  <= rdData_d;
			rdValid_q <= regRdEn;
		end
	end

	// Shadows start at the reset values of their registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			commonMask_q <= `BGP_MASK_ZERO;
			deformMask_q <= `BGP_MASK_ZERO;
			signSel_q    <= bgp_mask_t'(`BGP_RST_POLARITY);
		end
		else
		begin
			commonMask_q <= commonMask_d;
			deformMask_q <= deformMask_d;
			signSel_q    <= signSel_d;
		end
	end

	// The value sign uses the setting the update itself takes, not the older shadow
	bgp_channel uChannel0
	(
		.clk            (clk),
		.rst            (rst),
		.algoUpdate     (algoUpdate),
		.valueSignSel   (signSel_d[0]),
		.pinLevelSel    (pin_level_sel_ch0),
		.buttonPressed  (buttonPressed[0]),
		.rawValue       (coil_frequency_ch0),
		.processedValue (processed_value_ch0),
		.buttonPin      (button_pin_ch0)
	);

	bgp_channel uChannel1
	(
		.clk            (clk),
		.rst            (rst),
		.algoUpdate     (algoUpdate),
		.valueSignSel   (signSel_d[1]),
		.pinLevelSel    (pin_level_sel_ch1),
		.buttonPressed  (buttonPressed[1]),
		.rawValue       (coil_frequency_ch1),
		.processedValue (processed_value_ch1),
		.buttonPin      (button_pin_ch1)
	);

	bgp_channel uChannel2
	(
		.clk            (clk),
		.rst            (rst),
		.algoUpdate     (algoUpdate),
		.valueSignSel   (signSel_d[2]),
		.pinLevelSel    (pin_level_sel_ch2),
		.buttonPressed  (buttonPressed[2]),
		.rawValue       (coil_frequency_ch2),
		.processedValue (processed_value_ch2),
		.buttonPin      (button_pin_ch2)
	);

	bgp_channel uChannel3
	(
		.clk            (clk),
		.rst            (rst),
		.algoUpdate     (algoUpdate),
		.valueSignSel   (signSel_d[3]),
		.pinLevelSel    (pin_level_sel_ch3),
		.buttonPressed  (buttonPressed[3]),
		.rawValue       (coil_frequency_ch3),
		.processedValue (processed_value_ch3),
		.buttonPin      (button_pin_ch3)
	);

	assign commonGroupMask     = commonMask_q;
	assign deformGroupMask     = deformMask_q;
	assign regRdData           = rdData_q;
	assign regRdValid          = rdValid_q;
endmodule // bgp_top

`default_nettype wire
